// File: gdcs_top.sv
`timescale 1ns/10ps
`include "gdcs_regs.svh"
module gdcs_top
  import gdcs_pkg::*;
#(
  parameter int SEC_CYCLES   = `GDCS_SEC_CYCLES,
  parameter int BLINK_CYCLES = `GDCS_BLINK_CYCLES,
  parameter int LOG_DEPTH    = `GDCS_LOG_DEPTH
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire gdcs_pins_s                   pins_raw,
  input  wire logic [11:0]                  adc_data,
  input  wire logic [$clog2(LOG_DEPTH)-1:0] log_rd_addr,
  output logic      [23:0]                  log_rd_data,
  output logic      [3:0]                   log_count,
  output gdcs_entry_s                       cal,
  output gdcs_status_s                      status,
  output logic                              cal_led,
  output logic                              red_led,
  output logic                              fault
);
  localparam int TW = $clog2(SEC_CYCLES + 1);
  localparam int BW = $clog2(BLINK_CYCLES + 1);
  localparam int AW = $clog2(LOG_DEPTH);

  gdcs_pins_s       pins_meta;
  gdcs_pins_s       pins_s;
  gdcs_pins_s       pins_d;
  gdcs_state_e      state;
  gdcs_state_e      next_state;
  logic [TW-1:0]    tick_cnt;
  logic [BW-1:0]    blink_cnt;
  logic             blink_ph;
  logic [5:0]       sec_cnt;
  logic [9:0]       tmo_cnt;
  logic             repl;
  logic             next_repl;
  logic             blocked;
  logic             slot_held;
  logic [AW-1:0]    cur_slot;
  logic [AW-1:0]    log_ptr;
  logic [11:0]      zraw;
  logic [11:0]      stab_ref;
  gdcs_entry_s      backup;
  logic             cap_zero;
  logic             cap_span;
  logic             finish_ok;
  logic             do_abort;

  // states that blink or light the calibrate led
  function automatic logic is_blink(input gdcs_state_e st);
    is_blink = (st == ST_ZERO_REED) || (st == ST_ZERO_AUTO) || (st == ST_SPAN_REED) ||
               (st == ST_SPAN_AUTO) || (st == ST_ABORTED);
  endfunction

  function automatic logic is_steady(input gdcs_state_e st);
    is_steady = (st == ST_RISE) || (st == ST_END_REED) || (st == ST_END_FALL);
  endfunction

  // states timed by a reed hold
  function automatic logic is_reed_st(input gdcs_state_e st);
    is_reed_st = (st == ST_ARM) || (st == ST_ZERO_REED) || (st == ST_SPAN_REED);
  endfunction

  // two-flop synchroniser plus one delay stage for edges
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pins_meta <= '0;
      pins_s    <= '0;
      pins_d    <= '0;
    end
    else
    begin
      pins_meta <= pins_raw;
      pins_s    <= pins_meta;
      pins_d    <= pins_s;
    end
  end

  // pin edges and decoded conditions
  wire        reed       = pins_s.reed;
  wire        auto_md    = pins_s.auto_mode;
  wire        reed_edge  = pins_s.reed ^ pins_d.reed;
  wire        reed_rise  = pins_s.reed & ~pins_d.reed;
  wire        repl_press = pins_s.replace & ~pins_d.replace;
  wire        mrst_press = pins_s.mod_reset & ~pins_d.mod_reset;
  wire        busy       = (state != ST_IDLE) && (state != ST_ARM) && (state != ST_ABORTED);
  wire        tick       = (tick_cnt == TW'(SEC_CYCLES - 1));
  wire        held       = reed && !blocked;
  wire        hold_ok    = held && (sec_cnt >= `GDCS_HOLD_S);
  wire [12:0] rise_lvl   = {1'b0, cal.zero} + {1'b0, `GDCS_RISE_DELTA};
  wire        rising     = {1'b0, adc_data} > rise_lvl;
  wire [11:0] stab_diff  = (adc_data > stab_ref) ? adc_data - stab_ref : stab_ref - adc_data;
  wire        unstable   = stab_diff > `GDCS_STAB_BAND;
  wire        below_low  = adc_data < 12'(`GDCS_LOW_THRESH);
  wire        tmo_hit    = busy && !repl && (tmo_cnt >= 10'(`GDCS_TIMEOUT_S));
  wire        abort_req  = tmo_hit || (busy && repl && mrst_press);
  wire        restart    = (next_state != state) || (reed_edge && is_reed_st(state)) ||
                           ((state == ST_SPAN_AUTO) && unstable);

  // sequencer decisions
  always_comb
  begin
    next_state = state;
    next_repl  = repl;
    cap_zero   = 1'b0;
    cap_span   = 1'b0;
    finish_ok  = 1'b0;
    do_abort   = 1'b0;
    if (repl_press)
    begin
      next_state = ST_ZERO_REED;
      next_repl  = 1'b1;
    end
    else if (abort_req)
    begin
      do_abort   = 1'b1;
      next_state = ST_ABORTED;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (reed)
          begin
            next_state = ST_ARM;
          end
        end
        ST_ARM:
        begin
          if (!reed)
          begin
            next_state = ST_IDLE;
          end
          else if (auto_md && sec_cnt >= `GDCS_AUTO_INIT_S)
          begin
            next_state = ST_ZERO_AUTO;
            next_repl  = 1'b0;
          end
          else if (!auto_md && sec_cnt >= `GDCS_HOLD_S)
          begin
            next_state = ST_ZERO_REED;
            next_repl  = 1'b0;
          end
        end
        ST_ZERO_REED:
        begin
          if (hold_ok)
          begin
            cap_zero   = 1'b1;
            next_state = ST_RISE;
          end
        end
        ST_ZERO_AUTO:
        begin
          if (sec_cnt >= `GDCS_AUTO_ZERO_S)
          begin
            cap_zero   = 1'b1;
            next_state = ST_RISE;
          end
        end
        ST_RISE:
        begin
          if (rising)
          begin
            next_state = (auto_md && !repl) ? ST_SPAN_AUTO : ST_SPAN_REED;
          end
        end
        ST_SPAN_REED:
        begin
          if (hold_ok)
          begin
            cap_span   = 1'b1;
            next_state = auto_md ? ST_END_FALL : ST_END_REED;
          end
        end
        ST_SPAN_AUTO:
        begin
          if (!unstable && sec_cnt >= `GDCS_STABLE_S)
          begin
            cap_span   = 1'b1;
            next_state = ST_END_FALL;
          end
        end
        ST_END_REED:
        begin
          if (held)
          begin
            finish_ok  = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_END_FALL:
        begin
          if (below_low)
          begin
            finish_ok  = 1'b1;
            next_state = ST_IDLE;
          end
        end
        ST_ABORTED:
        begin
          if (sec_cnt >= `GDCS_ABORT_SHOW_S)
          begin
            next_state = ST_IDLE;
          end
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // log slot choice: slot one for replacement, roll over slots 2..8 when full
  wire          log_full   = log_count >= 4'(LOG_DEPTH);
  wire [AW-1:0] alloc_slot = repl ? `GDCS_INIT_SLOT :
                             (log_full ? log_ptr : log_count[AW-1:0]);
  wire          alloc      = cap_zero || (do_abort && !slot_held);
  wire          log_we     = cap_zero || cap_span || do_abort;
  wire [AW-1:0] log_waddr  = alloc ? alloc_slot : cur_slot;
  wire [23:0]   log_wdata  = do_abort ? `GDCS_CAL_RESET :
                             (cap_zero ? {adc_data, 12'h000} : {zraw, adc_data});
  wire [AW-1:0] ptr_wrap   = (log_ptr == AW'(LOG_DEPTH - 1)) ? `GDCS_FIRST_ROLL
                                                              : log_ptr + 1'b1;

  // seconds tick divider and second counter
  always_ff @(posedge mclk)
  begin
    if (!rst_n || restart)
    begin
      tick_cnt <= '0;
      sec_cnt  <= 6'h00;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      sec_cnt  <= (tick && sec_cnt != 6'h3f) ? sec_cnt + 1'b1 : sec_cnt;
    end
  end

  // free blink time base for both leds
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      blink_cnt <= '0;
      blink_ph  <= 1'b0;
    end
    else if (blink_cnt == BW'(BLINK_CYCLES - 1))
    begin
      blink_cnt <= '0;
      blink_ph  <= ~blink_ph;
    end
    else
    begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  // calibration timeout, counted only outside replacement
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !busy || repl || repl_press)
    begin
      tmo_cnt <= 10'h000;
    end
    else if (tick && !tmo_hit)
    begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // sequencer state, reed release gate, stability reference
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state    <= ST_IDLE;
      repl     <= 1'b0;
      blocked  <= 1'b0;
      stab_ref <= 12'h000;
    end
    else
    begin
      state    <= next_state;
      repl     <= (next_state == ST_IDLE) ? 1'b0 : next_repl;
      blocked  <= (next_state != state) ? 1'b1 : (blocked && reed);
      stab_ref <= restart ? adc_data : stab_ref;
    end
  end

  // working values, backup and restore
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cal    <= `GDCS_CAL_RESET;
      backup <= `GDCS_CAL_RESET;
      zraw   <= 12'h000;
    end
    else if (do_abort)
    begin
      cal <= backup;
    end
    else
    begin
      if (!busy && next_state != state && next_state != ST_IDLE && next_state != ST_ARM)
      begin
        backup <= cal;
      end
      if (cap_zero)
      begin
        zraw     <= adc_data;
        cal.zero <= adc_data;
      end
      if (cap_span)
      begin
        cal.span <= adc_data;
      end
    end
  end

  // log bookkeeping
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      log_count <= 4'h0;
      log_ptr   <= `GDCS_FIRST_ROLL;
      cur_slot  <= `GDCS_INIT_SLOT;
      slot_held <= 1'b0;
    end
    else
    begin
      if (alloc)
      begin
        cur_slot <= alloc_slot;
        if (repl)
        begin
          log_count <= 4'h1;
          log_ptr   <= `GDCS_FIRST_ROLL;
        end
        else if (log_full)
        begin
          log_ptr <= ptr_wrap;
        end
        else
        begin
          log_count <= log_count + 1'b1;
        end
      end
      slot_held <= (next_state == ST_IDLE || do_abort || repl_press) ? 1'b0
                                                                     : (slot_held || cap_zero);
    end
  end

  // registered outputs: leds, fault, status
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cal_led <= 1'b0;
      red_led <= 1'b0;
      fault   <= 1'b0;
      status  <= '0;
    end
    else
    begin
      cal_led <= is_steady(state) || (is_blink(state) && blink_ph);
      red_led <= blink_ph && ((state == ST_ABORTED) || (reed && !auto_md) ||
                 (reed && state == ST_ARM && sec_cnt < `GDCS_RED_FLASH_S));
      fault   <= (adc_data == 12'h000) && !(busy && repl);
      status  <= '{busy: busy, replacing: repl, done: finish_ok, aborted: do_abort};
    end
  end

  gdcs_log_mem #(
    .DEPTH (LOG_DEPTH),
    .WIDTH (24)
  ) u_log (
    .mclk  (mclk),
    .we    (log_we),
    .waddr (log_waddr),
    .wdata (log_wdata),
    .raddr (log_rd_addr),
    .rdata (log_rd_data)
  );
endmodule // gdcs_top

// File: gdcs_regs.svh
`ifndef GDCS_REGS_SVH
`define GDCS_REGS_SVH
`define GDCS_CLK_HZ        10000000
`define GDCS_TICK_S        1
`define GDCS_SEC_CYCLES    (`GDCS_CLK_HZ * `GDCS_TICK_S)
`define GDCS_BLINK_MS      250
`define GDCS_BLINK_CYCLES  (`GDCS_CLK_HZ / 1000 * `GDCS_BLINK_MS)
`define GDCS_HOLD_S        6'h03
`define GDCS_AUTO_INIT_S   6'h04
`define GDCS_RED_FLASH_S   6'h03
`define GDCS_AUTO_ZERO_S   6'h04
`define GDCS_STABLE_S      6'h1e
`define GDCS_ABORT_SHOW_S  6'h0a
`define GDCS_TIMEOUT_MIN   12
`define GDCS_TIMEOUT_S     (`GDCS_TIMEOUT_MIN * 60)
`define GDCS_ADC_MAX       4095
`define GDCS_LOW_PCT       4
`define GDCS_LOW_THRESH    ((`GDCS_ADC_MAX * `GDCS_LOW_PCT) / 100)
`define GDCS_RISE_DELTA    12'h0a0
`define GDCS_STAB_BAND     12'h010
`define GDCS_LOG_DEPTH     8
`define GDCS_INIT_SLOT     3'h0
`define GDCS_FIRST_ROLL    3'h1
`define GDCS_CAL_RESET     24'h0000_0000
`endif

// File: gdcs_pkg.sv
package gdcs_pkg;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ARM       = 4'h1,
    ST_ZERO_REED = 4'h2,
    ST_ZERO_AUTO = 4'h3,
    ST_RISE      = 4'h4,
    ST_SPAN_REED = 4'h5,
    ST_SPAN_AUTO = 4'h6,
    ST_END_REED  = 4'h7,
    ST_END_FALL  = 4'h8,
    ST_ABORTED   = 4'h9
  } gdcs_state_e;

  // one calibration: raw zero and raw span counts
  typedef struct packed {
    logic [11:0] zero;
    logic [11:0] span;
  } gdcs_entry_s;

  // operator and module pins
  typedef struct packed {
    logic reed;
    logic replace;
    logic mod_reset;
    logic auto_mode;
  } gdcs_pins_s;

  typedef struct packed {
    logic busy;
    logic replacing;
    logic done;
    logic aborted;
  } gdcs_status_s;
endpackage

// File: gdcs_log_mem.sv
`timescale 1ns/10ps
module gdcs_log_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 24
) (
  input  wire logic                     mclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write port, registered read port
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // gdcs_log_mem

// File: gdcs_monitor.sv
`timescale 1ns/10ps
module gdcs_monitor
  import gdcs_pkg::*;
#(
  parameter int SEC_CYCLES   = 20,
  parameter int BLINK_CYCLES = 4,
  parameter int LOG_DEPTH    = 8
) (
  input wire logic                         mclk,
  input wire logic                         rst_n,
  input wire gdcs_pins_s                   pins_raw,
  input wire logic [11:0]                  adc_data,
  input wire logic [$clog2(LOG_DEPTH)-1:0] log_rd_addr,
  input wire logic [23:0]                  log_rd_data,
  input wire logic [3:0]                   log_count,
  input wire gdcs_entry_s                  cal,
  input wire gdcs_status_s                 status,
  input wire logic                         cal_led,
  input wire logic                         red_led,
  input wire logic                         fault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        busy_q;
  gdcs_entry_s saved_cal;
  // calibration in force when a run starts
  always_ff @(posedge mclk)
  begin
    busy_q <= rst_n & status.busy;
    if (!rst_n)
      saved_cal <= '0;
    else if (status.busy && !busy_q)
      saved_cal <= cal;
  end
  // input alive, and a replacement run under way
  sequence s_live_input;
    (adc_data != 12'h000) [*2];
  endsequence
  sequence s_repl_busy;
    (status.busy && status.replacing) [*3];
  endsequence
  a_fault_live_input: assert property (s_live_input |-> !fault)
    else $error("fault raised on a nonzero input");
  a_fault_repl_masked: assert property (s_repl_busy |-> !fault)
    else $error("fault raised during replacement");
  a_done_one_pulse: assert property (status.done |=> !status.done)
    else $error("done pulse longer than one cycle");
  a_abort_one_pulse: assert property (status.aborted |=> !status.aborted)
    else $error("aborted pulse longer than one cycle");
  a_done_led_off: assert property (status.done |-> ##[0:3] !cal_led)
    else $error("calibrate led still lit after completion");
  a_abort_restores_cal: assert property (status.aborted |-> ##[0:3] (cal == saved_cal))
    else $error("previous calibration not restored on abort");
  a_log_count_range: assert property (log_count <= LOG_DEPTH)
    else $error("log count beyond log depth");
  a_log_count_step: assert property ($changed(log_count) |->
      (log_count == $past(log_count) + 4'h1) || (log_count == 4'h1))
    else $error("log count moved by other than one entry");
endmodule // gdcs_monitor

bind gdcs_top gdcs_monitor #(
  .SEC_CYCLES   (SEC_CYCLES),
  .BLINK_CYCLES (BLINK_CYCLES),
  .LOG_DEPTH    (LOG_DEPTH)
) mon_u (
  .mclk        (mclk),
  .rst_n       (rst_n),
  .pins_raw    (pins_raw),
  .adc_data    (adc_data),
  .log_rd_addr (log_rd_addr),
  .log_rd_data (log_rd_data),
  .log_count   (log_count),
  .cal         (cal),
  .status      (status),
  .cal_led     (cal_led),
  .red_led     (red_led),
  .fault       (fault)
);

// File: gdcs_operator.sv
`timescale 1ns/10ps
module gdcs_operator
  import gdcs_pkg::*;
#(
  parameter int SEC = 20
) (
  input  wire logic        mclk,
  output gdcs_pins_s       pins,
  output logic      [11:0] adc
);
  // hands off the unit at start
  initial
  begin
    pins = '0;
    adc  = 12'h100;
  end
  // magnet on or off the reed switch
  task automatic reed(input logic v);
    @(posedge mclk);
    pins.reed <= v;
  endtask
  task automatic auto(input logic v);
    @(posedge mclk);
    pins.auto_mode <= v;
  endtask
  task automatic put(input logic [11:0] v);
    @(posedge mclk);
    adc <= v;
  endtask
  // seconds plus slack for the pin synchronisers
  task automatic wait_s(input int n);
    repeat (n * SEC + 10) @(posedge mclk);
  endtask
  // replacement switch held about one second
  task automatic press;
    @(posedge mclk);
    pins.replace <= 1'h1;
    repeat (SEC) @(posedge mclk);
    pins.replace <= 1'h0;
  endtask
  task automatic mod_rst;
    @(posedge mclk);
    pins.mod_reset <= 1'h1;
    repeat (4) @(posedge mclk);
    pins.mod_reset <= 1'h0;
  endtask
endmodule // gdcs_operator

// File: gdcs_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb;
  import gdcs_pkg::*;
  localparam int         SEC = 20;
  localparam logic [1:0] OFF = 2'h0;
  localparam logic [1:0] BL  = 2'h1;
  localparam logic [1:0] ON  = 2'h2;
  logic         mclk;
  logic         rst_n;
  gdcs_pins_s   pins;
  logic [11:0]  adc;
  logic [2:0]   rd_addr;
  logic [23:0]  rd_data;
  logic [3:0]   cnt;
  gdcs_entry_s  cal;
  gdcs_status_s st;
  logic         cal_led;
  logic         red_led;
  logic         fault;
  logic [1:0]   m;
  logic [23:0]  d;
  int           n_fail = 0;
  int           samples_checked = 0;

  gdcs_top #(.SEC_CYCLES(SEC), .BLINK_CYCLES(4), .LOG_DEPTH(8)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .pins_raw(pins), .adc_data(adc), .log_rd_addr(rd_addr),
    .log_rd_data(rd_data), .log_count(cnt), .cal(cal), .status(st), .cal_led(cal_led),
    .red_led(red_led), .fault(fault));
  gdcs_operator #(.SEC(SEC)) op_u (.mclk(mclk), .pins(pins), .adc(adc));

  // 10 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // led over four half periods: off, blinking or steady
  task automatic led(input logic sel, output logic [1:0] md);
    int k;
    k = 0;
    repeat (16)
    begin
      @(negedge mclk);
      k += sel ? red_led : cal_led;
    end
    md = (k == 0) ? OFF : (k == 16) ? ON : BL;
  endtask
  task automatic rd(input logic [2:0] a, output logic [23:0] v);
    @(posedge mclk);
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    v = rd_data;
  endtask
  task automatic hold_s(input int n);
    op_u.reed(1'h1);
    op_u.wait_s(n);
    op_u.reed(1'h0);
    op_u.wait_s(0);
  endtask
  // one automatic run from zero gas to gas removal
  task automatic auto_run(input logic [11:0] z, input logic [11:0] s);
    op_u.auto(1'h1);
    op_u.put(z);
    op_u.reed(1'h1);
    op_u.wait_s(1);
    led(1'h1, m);
    `CHK(m, BL)
    op_u.wait_s(0);
    led(1'h0, m);
    `CHK(m, OFF)
    op_u.wait_s(3);
    led(1'h0, m);
    `CHK(m, BL)
    led(1'h1, m);
    `CHK(m, OFF)
    op_u.reed(1'h0);
    op_u.wait_s(4);
    led(1'h0, m);
    `CHK({cal.zero, m}, {z, ON})
    op_u.put(s);
    op_u.wait_s(0);
    led(1'h0, m);
    `CHK(m, BL)
    op_u.wait_s(27);
    led(1'h0, m);
    `CHK(m, BL)
    op_u.wait_s(2);
    led(1'h0, m);
    `CHK({cal.span, m}, {s, ON})
    op_u.put(12'h0a3);
    op_u.wait_s(1);
    `CHK(st.busy, 1'h1)
    op_u.put(12'h0a2);
    op_u.wait_s(0);
    led(1'h0, m);
    `CHK({st.busy, m}, {1'h0, OFF})
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard, well beyond the whole sequence
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    rst_n = 1'h0;
    rd_addr = 3'h0;
    repeat (7) @(posedge mclk);
    @(negedge mclk);
    `CHK({cal, st, cal_led, red_led, fault, cnt}, 35'h0)
    @(posedge mclk);
    rst_n <= 1'h1;
    // manual run
    op_u.reed(1'h1);
    op_u.wait_s(3);
    led(1'h1, m);
    `CHK(m, BL)
    led(1'h0, m);
    `CHK(m, BL)
    op_u.reed(1'h0);
    op_u.wait_s(0);
    hold_s(3);
    led(1'h0, m);
    `CHK({cal.zero, m}, {12'h100, ON})
    op_u.put(12'h1a0);
    op_u.wait_s(0);
    led(1'h0, m);
    `CHK(m, ON)
    op_u.put(12'h1a1);
    op_u.wait_s(0);
    led(1'h0, m);
    `CHK(m, BL)
    hold_s(3);
    led(1'h0, m);
    `CHK({cal.span, m}, {12'h1a1, ON})
    hold_s(0);
    led(1'h0, m);
    `CHK({st.busy, m}, {1'h0, OFF})
    rd(3'h0, d);
    `CHK({cnt, d}, {4'h1, 24'h10_01a1})
    auto_run(12'h120, 12'h900);
    rd(3'h1, d);
    `CHK({cnt, d}, {4'h2, 24'h12_0900})
    // manual run left to time out after zero capture
    op_u.auto(1'h0);
    op_u.put(12'h648);
    hold_s(3);
    hold_s(3);
    op_u.wait_s(716);
    `CHK(cal, 24'h12_0900)
    led(1'h0, m);
    `CHK(m, BL)
    led(1'h1, m);
    `CHK(m, BL)
    rd(3'h2, d);
    `CHK(d, 24'h0)
    op_u.wait_s(10);
    // replacement restarted, then aborted by module reset
    op_u.put(12'h110);
    op_u.press;
    led(1'h0, m);
    `CHK({st.busy, st.replacing, m}, {2'h3, BL})
    hold_s(3);
    rd(3'h0, d);
    `CHK(d, 24'h11_0000)
    op_u.press;
    led(1'h0, m);
    `CHK(m, BL)
    op_u.mod_rst;
    op_u.wait_s(11);
    rd(3'h0, d);
    `CHK({st.busy, d}, {1'h0, 24'h0})
    // full replacement from a dead input
    op_u.put(12'h000);
    op_u.wait_s(0);
    `CHK(fault, 1'h1)
    op_u.press;
    op_u.wait_s(0);
    `CHK(fault, 1'h0)
    op_u.put(12'h100);
    hold_s(3);
    op_u.put(12'h900);
    op_u.wait_s(0);
    hold_s(3);
    led(1'h0, m);
    `CHK({cal, m}, {24'h10_0900, ON})
    hold_s(0);
    rd(3'h0, d);
    `CHK({cnt, d}, {4'h1, 24'h10_0900})
    // eight routine runs fill the log and wrap to slot two
    for (int i = 0; i < 8; i++)
      auto_run(12'h100 + 12'(i), 12'h800 + 12'(i));
    rd(3'h1, d);
    `CHK({cnt, d}, {4'h8, 24'h10_7807})
    rd(3'h0, d);
    `CHK(d, 24'h10_0900)
    rd(3'h2, d);
    `CHK(d, 24'h10_1801)
    // remaining slots hold the later routine runs in order
    for (int s = 3; s < 8; s++)
    begin
      rd(3'(s), d);
      `CHK(d, {12'h0ff + 12'(s), 12'h7ff + 12'(s)})
    end
    report_and_stop();
  end
endmodule // tb
